/* src/lnst_frame_watch.sv */
`timescale 1ns/100ps
`default_nettype none
module lnst_frame_watch
  import lnst_pkg::*;
#(
  parameter int unsigned NODES = NODE_MAX
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic frm_valid,
  input wire logic [SLOT_W-1:0] frm_slot,
  input wire logic cycle_end,
  input wire logic [SLOT_W:0] table_size,
  output logic [NODES-1:0] comm_err
);
  // ------------------------------------------------------------
  // Silence detection per token rotation
  // ------------------------------------------------------------
  // A frame arriving in the very cycle of the rotation end counts for the closing rotation.
  logic [NODES-1:0] seen;
  logic [NODES-1:0] hit;
  logic [NODES-1:0] in_table;
  logic [NODES-1:0] seen_now;

  for (genvar i = 0; i < NODES; i++) begin : g_slot
    assign hit[i] = frm_valid && (frm_slot == SLOT_W'(i));
    assign in_table[i] = (SLOT_W+1)'(i) < table_size;
  end
  assign seen_now = seen | hit;

  always_ff @(posedge mclk) begin
    if (rst) begin
      seen <= '0;
      comm_err <= '0;
    end else if (ce && enable) begin
      if (cycle_end) begin
        seen <= '0;
        comm_err <= in_table & ~seen_now;
      end else begin
        seen <= seen_now;
      end
    end
  end
endmodule
`default_nettype wire

/* src/lnst_pkg.sv */
package lnst_pkg;
  localparam int unsigned NODE_MAX = 62;
  localparam int unsigned SLOT_W = 6;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] STATUS_FIRST_OFS = 5'h08;
  localparam logic [4:0] STATUS_LAST_OFS = 5'h17;
  localparam logic [4:0] LOCAL_WORD_OFS = 5'h17;
  localparam int unsigned NODES_PER_WORD = 4;
  localparam int unsigned BIT_RUN = 0;
  localparam int unsigned BIT_FATAL = 1;
  localparam int unsigned BIT_COMM_ERR = 2;
  localparam int unsigned BIT_ACTIVE = 3;
  localparam int unsigned STARTUP_LSB = 8;
  localparam int unsigned LOCAL_ACTIVE_BIT = 15;
  localparam logic [5:0] STARTUP_MIN = 6'h01;
  localparam logic [5:0] STARTUP_MAX = 6'h3e;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  typedef enum logic [1:0] {
    LNST_MODE_PROGRAM,
    LNST_MODE_RUN,
    LNST_MODE_MONITOR
  } lnst_mode_e;
endpackage

/* src/lnst_status_bank.sv */
`timescale 1ns/100ps
`default_nettype none
module lnst_status_bank
  import lnst_pkg::*;
#(
  parameter int unsigned NODES = NODE_MAX
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic link_active,
  input wire logic [SLOT_W-1:0] startup_addr,
  input wire logic [SLOT_W:0] table_size,
  input wire logic frm_valid,
  input wire logic [SLOT_W-1:0] frm_slot,
  input wire logic [1:0] frm_mode,
  input wire logic frm_fatal,
  input wire logic cycle_end,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [WORD_W-1:0] rd_data,
  output logic rd_valid
);
  // ------------------------------------------------------------
  // Per-node state
  // ------------------------------------------------------------
  logic [NODES-1:0] run_flag;
  logic [NODES-1:0] fatal_flag;
  logic [NODES-1:0] active_flag;
  logic [NODES-1:0] comm_err;
  logic local_active;
  logic [SLOT_W-1:0] startup_node;
  logic link_active_d;

  // Frames for slots outside the refresh table are dropped.
  wire frm_take = frm_valid && ({1'b0, frm_slot} < table_size);
  wire mode_running = (frm_mode == LNST_MODE_RUN) || (frm_mode == LNST_MODE_MONITOR);
  wire link_start = link_active && !link_active_d;
  wire startup_ok = (startup_addr >= STARTUP_MIN) && (startup_addr <= STARTUP_MAX);

  lnst_frame_watch #(
    .NODES(NODES)
  ) u_watch (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .enable(link_active),
    .frm_valid(frm_take),
    .frm_slot(frm_slot),
    .cycle_end(cycle_end),
    .table_size(table_size),
    .comm_err(comm_err)
  );

  // ------------------------------------------------------------
  // Node flag update
  // ------------------------------------------------------------
  // Only the addressed slot changes, so each flag keeps its value until its own node reports again.
  logic [NODES-1:0] hit;
  logic [NODES-1:0] next_run;
  logic [NODES-1:0] next_fatal;
  logic [NODES-1:0] next_active;

  for (genvar i = 0; i < NODES; i++) begin : g_node
    assign hit[i] = frm_take && (frm_slot == SLOT_W'(i));
    // A fatal error keeps the run flag as it was, so a node that failed while running still shows running.
    assign next_run[i] = (hit[i] && !frm_fatal) ? mode_running : run_flag[i];
    assign next_fatal[i] = hit[i] ? frm_fatal : fatal_flag[i];
    assign next_active[i] = active_flag[i] | hit[i];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      run_flag <= '0;
      fatal_flag <= '0;
      active_flag <= '0;
    end else if (ce && link_active) begin
      run_flag <= next_run;
      fatal_flag <= next_fatal;
      active_flag <= next_active;
    end
  end

  // ------------------------------------------------------------
  // Local node state
  // ------------------------------------------------------------
  // An out-of-range startup address is not stored; the previous value is kept.
  always_ff @(posedge mclk) begin
    if (rst) begin
      local_active <= 1'b0;
      link_active_d <= 1'b0;
      startup_node <= '0;
    end else if (ce) begin
      local_active <= link_active;
      link_active_d <= link_active;
      if (link_start && startup_ok) begin
        startup_node <= startup_addr;
      end
    end
  end

  // ------------------------------------------------------------
  // Word packing and read port
  // ------------------------------------------------------------
  function automatic logic [3:0] node_nibble(input int unsigned n);
    logic [3:0] nib;
    nib = '0;
    if (n < NODES) begin
      nib[BIT_RUN] = run_flag[n];
      nib[BIT_FATAL] = fatal_flag[n];
      nib[BIT_COMM_ERR] = comm_err[n];
      nib[BIT_ACTIVE] = active_flag[n];
    end
    return nib;
  endfunction

  wire in_range = (rd_addr >= STATUS_FIRST_OFS) && (rd_addr <= STATUS_LAST_OFS);
  wire [ADDR_W-1:0] word_idx = rd_addr - STATUS_FIRST_OFS;
  wire is_local_word = (rd_addr == LOCAL_WORD_OFS);

  logic [WORD_W-1:0] packed_word;
  always_comb begin
    packed_word = WORD_RESET;
    if (in_range) begin
      for (int unsigned k = 0; k < NODES_PER_WORD; k++) begin
        packed_word[k*4 +: 4] = node_nibble(int'(word_idx) * NODES_PER_WORD + k);
      end
      if (is_local_word) begin
        packed_word[STARTUP_LSB +: SLOT_W] = startup_node;
        packed_word[LOCAL_ACTIVE_BIT] = local_active;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data <= WORD_RESET;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= packed_word;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/lnst_peer_model.sv */
`timescale 1ns/100ps
`default_nettype none
module lnst_peer_model
  import lnst_pkg::*;
(
  input wire logic mclk, input wire logic rot, input wire logic [7:0] alive,
  input wire logic [1:0] mode, input wire logic fatal, output logic frm_valid,
  output logic [SLOT_W-1:0] frm_slot, output logic [1:0] frm_mode, output logic frm_fatal, output logic cycle_end
);
  // Idle slot lines toggle so a stale value can never pass for a frame.
  logic [2:0] n = 3'h0;
  initial {frm_valid, frm_slot, frm_mode, frm_fatal, cycle_end} = '0;
  always @(negedge mclk) begin
    frm_valid <= rot && alive[n];
    frm_slot <= rot ? {3'h0, n} : ~frm_slot;
    frm_mode <= mode;
    frm_fatal <= fatal;
    cycle_end <= rot && n == 3'h7;
    n <= rot ? n + 3'h1 : 3'h0;
  end
endmodule
`default_nettype wire

/* testbench/lnst_status_bank_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module lnst_status_bank_asserts
  import lnst_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic link_active,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic [WORD_W-1:0] rd_data,
  input wire logic rd_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire rd = ce && rd_en;
  wire loc = rd && rd_addr == LOCAL_WORD_OFS;
  wire bad = rd && (rd_addr < STATUS_FIRST_OFS || rd_addr > STATUS_LAST_OFS);
  a_read_answer: assert property (rd |=> rd_valid) else $error("no answer");
  a_no_spurious: assert property (ce && !rd_en |=> !rd_valid && $stable(rd_data)) else $error("spurious");
  a_ce_freeze: assert property (!ce |=> $stable(rd_data) && $stable(rd_valid)) else $error("not frozen");
  a_unmapped_zero: assert property (bad |=> rd_data == WORD_RESET) else $error("unmapped");
  a_spare_bit: assert property (loc |=> !rd_data[14]) else $error("bit 14");
  a_startup_range: assert property (loc |=> rd_data[13:8] <= STARTUP_MAX) else $error("startup");
  a_local_flag: assert property (loc && $stable(link_active) && $past(ce) && !$past(rst)
    |=> rd_data[15] == $past(link_active)) else $error("local flag");
  a_reset_clear: assert property ($fell(rst) && $past(ce) |-> rd_data == WORD_RESET && !rd_valid)
    else $error("reset");
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import lnst_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, link_active = 1'b0, rd_en = 1'b0, rot = 1'b0, fatal = 1'b0;
  logic ce_seen = 1'b0;
  logic [SLOT_W:0] tsz = 7'h08;
  logic frm_valid, frm_fatal, cycle_end, rd_valid;
  logic [SLOT_W-1:0] startup_addr = 6'h00, sa = 6'h00, frm_slot;
  logic [1:0] mode = 2'h0, frm_mode;
  logic [7:0] alive = 8'h00;
  logic [ADDR_W-1:0] rd_addr = 5'h00;
  logic [WORD_W-1:0] rd_data, q[$];
  logic [3:0] nib[8] = '{default: 4'h0};
  int fails = 0, samples_checked = 0, cyc = 0;
  lnst_peer_model lnst_peer_model_i (.mclk, .rot, .alive, .mode, .fatal, .frm_valid, .frm_slot, .frm_mode,
    .frm_fatal, .cycle_end);
  lnst_status_bank lnst_status_bank_i (.mclk, .rst, .ce, .link_active, .startup_addr, .table_size(tsz),
    .frm_valid, .frm_slot, .frm_mode, .frm_fatal, .cycle_end, .rd_en, .rd_addr, .rd_data, .rd_valid);
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) ce_seen <= ce;
  // A read answer stands while the enable is low, so it is taken only after an enabled edge.
  always @(negedge mclk) if (rd_valid === 1'b1 && ce_seen) chk(q.pop_front(), rd_data);
  always @(posedge mclk) if (++cyc > 3000) begin fails++; report_and_stop(); end
  task chk(input logic [WORD_W-1:0] e, g);
    samples_checked++;
    if (e !== g) begin fails++; $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g); end
  endtask
  task report_and_stop();
    $display("compared %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task readall();
    logic [WORD_W-1:0] e[4];
    logic [ADDR_W-1:0] a[4];
    e = '{{nib[3], nib[2], nib[1], nib[0]}, {nib[7], nib[6], nib[5], nib[4]}, {link_active, 1'b0, sa, 8'h00}, 16'h0};
    a = '{5'h08, 5'h09, LOCAL_WORD_OFS, 5'h1f};
    rd_en = 1'b1;
    for (int k = 0; k < 4; k++) begin rd_addr = a[k]; q.push_back(e[k]); @(negedge mclk); end
    rd_en = 1'b0;
    ce = 1'b0;
    repeat (2) @(negedge mclk);
    ce = 1'b1;
    @(negedge mclk);
  endtask
  task rotate();
    rot <= 1'b1;
    repeat (8) @(negedge mclk);
    rot <= 1'b0;
    repeat (3) @(negedge mclk);
    for (int s = 0; s < 8; s++) begin
      if (link_active && s >= tsz) nib[s][2] = 1'b0;
      else if (link_active && alive[s]) nib[s] = {2'b10, fatal, fatal ? nib[s][0] : mode == 2'h1 || mode == 2'h2};
      else if (link_active) nib[s][2] = 1'b1;
    end
  endtask
  initial begin
    void'($urandom(65668));
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    readall();
    $display("reset test done");
    sa = 6'($urandom_range(62, 1));
    startup_addr = sa;
    link_active = 1'b1;
    @(negedge mclk);
    startup_addr = 6'h3f;
    for (int i = 0; i < 8; i++) begin
      mode = i[1:0];
      fatal = i > 3 && $urandom_range(1, 0) == 1;
      alive = 8'($urandom);
      tsz = 7'($urandom_range(8, 5));
      link_active = i != 6;
      rotate();
      readall();
      $display("rotation test %0d done", i);
    end
    report_and_stop();
  end
endmodule
bind lnst_status_bank lnst_status_bank_asserts lnst_status_bank_asserts_i (.mclk, .rst, .ce, .link_active,
  .rd_en, .rd_addr, .rd_data, .rd_valid);
`default_nettype wire
